// [src/pmr_pkg.sv]
// Constants, field positions and address maps for the port management register bank.
// Assumes one core clock; the serial management pins are synchronised inside the top module.
package pmr_pkg;

  // ----------------------------------------------------------------
  // Management register numbers and port addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] MII_BASIC_CONTROL = 5'h00;
  localparam logic [4:0] MII_BASIC_STATUS = 5'h01;
  localparam logic [4:0] MII_ID_HIGH = 5'h02;
  localparam logic [4:0] MII_ID_LOW = 5'h03;
  localparam logic [4:0] MII_ADVERTISE = 5'h04;
  localparam logic [4:0] MII_PARTNER = 5'h05;
  localparam logic [4:0] PHYAD_PORT1 = 5'h01;
  localparam logic [4:0] PHYAD_PORT2 = 5'h02;

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h0c;
  localparam logic [5:0] DATA_LAST = 6'h0f;

  // ----------------------------------------------------------------
  // Byte register map
  // ----------------------------------------------------------------
  localparam logic [6:0] SW_CHIP_ID0 = 7'h00;
  localparam logic [6:0] SW_CHIP_ID1 = 7'h01;
  localparam logic [6:0] SW_GLOBAL_LO = 7'h02;
  localparam logic [6:0] SW_RESERVED = 7'h0c;
  localparam logic [6:0] SW_USER_HI = 7'h0f;
  localparam logic [6:0] SW_P1_FAULT = 7'h1f;
  localparam logic [6:0] SW_CA_ADDR [2] = '{7'h1c, 7'h2c};
  localparam logic [6:0] SW_CB_ADDR [2] = '{7'h1d, 7'h2d};
  localparam logic [6:0] SW_ST_ADDR [2] = '{7'h1e, 7'h2e};
  localparam logic [7:0] CB_MASK [2] = '{8'hff, 8'hef};
  localparam logic [7:0] CA_RESET = 8'h9f;
  localparam logic [7:0] CB_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Byte control fields (registers 28/44 as CA, 29/45 as CB, 30/46 as ST)
  // ----------------------------------------------------------------
  localparam int CA_ABIL_LO = 0;
  localparam int CA_PAUSE = 4;
  localparam int CA_FULL = 5;
  localparam int CA_FORCE100 = 6;
  localparam int CA_AN_CAP = 7;
  localparam int CB_LOOPBACK = 0;
  localparam int CB_FORCE_MDI = 1;
  localparam int CB_NO_MDIX = 2;
  localparam int CB_POWER_DOWN = 3;
  localparam int CB_NO_FEF = 4;
  localparam int CB_RESTART_AN = 5;
  localparam int CB_NO_TX = 6;
  localparam int CB_NO_LED = 7;
  localparam int ST_ABIL_LO = 0;
  localparam int ST_PAUSE = 4;
  localparam int ST_LINK = 5;
  localparam int ST_AN_DONE = 6;

  // ----------------------------------------------------------------
  // Management view fields
  // ----------------------------------------------------------------
  localparam int BC_LOOPBACK = 14;
  localparam int BC_FORCE100 = 13;
  localparam int BC_AN_EN = 12;
  localparam int BC_POWER_DOWN = 11;
  localparam int BC_RESTART_AN = 9;
  localparam int BC_FULL = 8;
  localparam int BC_FORCE_MDI = 4;
  localparam int BC_NO_MDIX = 3;
  localparam int BC_NO_FEF = 2;
  localparam int BC_NO_TX = 1;
  localparam int BC_NO_LED = 0;
  localparam logic [15:0] BS_CAP_BITS = 16'h7800;
  localparam int BS_AN_DONE = 5;
  localparam int BS_FEF = 4;
  localparam int BS_AN_CAP = 3;
  localparam int BS_LINK = 2;
  localparam int AD_PAUSE = 10;
  localparam int AD_RSVD9 = 9;
  localparam int AD_ABIL_LO = 5;
  localparam logic [4:0] AD_SELECTOR = 5'h01;

  // Serial engine states, Gray along preamble, header, turnaround, data
  typedef enum logic [1:0] {
    PMR_PRE = 2'b00,
    PMR_HDR = 2'b01,
    PMR_TA = 2'b11,
    PMR_DATA = 2'b10
  } pmr_state_t;

endpackage

// [src/pmr_store_if.sv]
// Interface between the bank top and its byte store.
// Assumes both ends sit on the core clock.
`timescale 1ns/1ps
interface pmr_store_if;
  logic wr;          // Write strobe, one cycle
  logic [3:0] addr;  // Byte index in the global region
  logic [7:0] wdata; // Write data
  logic [7:0] rdata; // Registered read data
  modport owner (output wr, output addr, output wdata, input rdata);
  modport mem (input wr, input addr, input wdata, output rdata);
endinterface

// [src/pmr_store.sv]
// Byte store for global control and user registers of the byte view.
// Assumes the owner blocks writes to read-only and reserved bytes.
`timescale 1ns/1ps
module pmr_store #(
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  pmr_store_if.mem bus
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] mem_q [DEPTH]; // Byte cells, cleared by reset
  logic [7:0] rdata_q;       // Read data register

  if (DEPTH < 16 || DEPTH > 16) begin : g_chk
    $error("pmr_store depth must match the 4-bit index");
  end

  // Write port and registered read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= 8'h00;
      end
      rdata_q <= 8'h00;
    end else begin
      if (bus.wr) begin
        mem_q[bus.addr] <= bus.wdata;
      end
      rdata_q <= mem_q[bus.addr];
    end
  end

  assign bus.rdata = rdata_q;
endmodule

// [src/pmr_top.sv]
// Port management register bank: serial management slave plus byte register view.
// Assumes MDC/MDIO come from a slow external controller; byte port and status are on CLK_SYS.
`timescale 1ns/1ps
module pmr_top
  import pmr_pkg::*;
#(
  parameter logic [15:0] ID_HIGH = 16'h5a01, // Arbitrary identifier value
  parameter logic [15:0] ID_LOW = 16'h0c3e,  // Arbitrary identifier value
  parameter logic [7:0] CHIP_ID0 = 8'h5c,    // Arbitrary family code
  parameter logic [6:0] CHIP_ID1 = 7'h02     // Arbitrary chip and revision code
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic MDC,
  input wire logic MDIO_I,
  output logic MDIO_O,
  output logic MDIO_OE,
  input wire logic [6:0] SW_ADDR,
  input wire logic SW_WE,
  input wire logic SW_RE,
  input wire logic [7:0] SW_WDATA,
  output logic [7:0] SW_RDATA,
  output logic SW_RVALID,
  input wire logic [6:0] PHY_STATUS_P1,
  input wire logic [6:0] PHY_STATUS_P2,
  input wire logic FAR_END_FAULT,
  output logic [7:0] CTRL_A_P1,
  output logic [7:0] CTRL_B_P1,
  output logic [7:0] CTRL_A_P2,
  output logic [7:0] CTRL_B_P2,
  output logic [1:0] AN_ENABLE,
  output logic START_SWITCH
);

  // ----------------------------------------------------------------
  // Shared storage (one copy per bit; ca, cb, st and fef seen by both views, the rest by one view only)
  // ----------------------------------------------------------------
  logic [7:0] ca_q [2];  // Advertise, force and capability bits
  logic [7:0] ca_d [2];
  logic [7:0] cb_q [2];  // Loopback, crossover, power, disables
  logic [7:0] cb_d [2];
  logic [6:0] st_q [2];  // Negotiation and link status snapshot
  logic [1:0] an_en_q;   // Negotiation enable, no byte mirror
  logic [1:0] an_en_d;
  logic [1:0] rsv9_q;    // Writable reserved advertise bit
  logic [1:0] rsv9_d;
  logic fef_q;           // Far-end fault, port 1 only
  logic start_q;         // Start bit, set once

  // Selects the management view of one register of one port
  function automatic logic [15:0] mii_view(input logic [4:0] regad, input logic [7:0] ca,
                                           input logic [7:0] cb, input logic [6:0] st,
                                           input logic fef, input logic an_en, input logic rsv9);
    logic [15:0] v;
    v = 16'h0000;
    case (regad)
      MII_BASIC_CONTROL: begin
        v[BC_LOOPBACK] = cb[CB_LOOPBACK];
        v[BC_FORCE100] = ca[CA_FORCE100];
        v[BC_AN_EN] = an_en;
        v[BC_POWER_DOWN] = cb[CB_POWER_DOWN];
        v[BC_RESTART_AN] = cb[CB_RESTART_AN];
        v[BC_FULL] = ca[CA_FULL];
        v[BC_FORCE_MDI] = cb[CB_FORCE_MDI];
        v[BC_NO_MDIX] = cb[CB_NO_MDIX];
        v[BC_NO_FEF] = cb[CB_NO_FEF];
        v[BC_NO_TX] = cb[CB_NO_TX];
        v[BC_NO_LED] = cb[CB_NO_LED];
      end
      MII_BASIC_STATUS: begin
        v = BS_CAP_BITS;
        // Capability bits fixed high, all other constant bits left zero
        v[BS_AN_DONE] = st[ST_AN_DONE];
        v[BS_LINK] = st[ST_LINK];
        v[BS_FEF] = fef;
        v[BS_AN_CAP] = ca[CA_AN_CAP];
      end
      MII_ID_HIGH: v = ID_HIGH;
      MII_ID_LOW: v = ID_LOW;
      MII_ADVERTISE: begin
        v[AD_PAUSE] = ca[CA_PAUSE];
        v[AD_RSVD9] = rsv9;
        v[AD_ABIL_LO +: 4] = ca[CA_ABIL_LO +: 4];
        v[4:0] = AD_SELECTOR;
      end
      MII_PARTNER: begin
        v[AD_PAUSE] = st[ST_PAUSE];
        v[AD_ABIL_LO +: 4] = st[ST_ABIL_LO +: 4];
      end
      // Unsupported register numbers read as zero
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers: three stages, change accepted when 2 and 3 agree
  // ----------------------------------------------------------------
  logic [2:0] mdc_s_q;   // MDC sync chain
  logic [2:0] mdio_s_q;  // MDIO sync chain
  logic mdc_q;           // Accepted MDC level
  logic mdio_q;          // Accepted MDIO level
  wire mdc_agree = (mdc_s_q[1] == mdc_s_q[2]);
  wire mdio_agree = (mdio_s_q[1] == mdio_s_q[2]);
  wire mdc_rise = mdc_agree && mdc_s_q[2] && !mdc_q;
  // Data level taken at the same moment the clock edge is accepted
  wire mdio_bit = mdio_agree ? mdio_s_q[2] : mdio_q;

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      mdc_s_q <= 3'h0;
      mdio_s_q <= 3'h7;
      mdc_q <= 1'b0;
      mdio_q <= 1'b1;
    end else begin
      mdc_s_q <= {mdc_s_q[1:0], MDC};
      mdio_s_q <= {mdio_s_q[1:0], MDIO_I};
      mdc_q <= mdc_agree ? mdc_s_q[2] : mdc_q;
      mdio_q <= mdio_bit;
    end
  end

  // ----------------------------------------------------------------
  // Serial frame engine
  // ----------------------------------------------------------------
  pmr_state_t state_q;   // Frame phase
  logic [5:0] cnt_q;     // Bit counter within a phase
  logic [12:0] hdr_q;    // Start, opcode, port and register bits
  logic [15:0] shf_q;    // Read or write data shifter
  logic rd_q;            // Current frame is a read
  logic hit_q;           // Frame addresses one of our ports
  logic port_q;          // Addressed port, 0 for port 1
  logic [4:0] reg_q;     // Addressed register number
  logic mii_wr_q;        // One-cycle write commit pulse
  logic mdio_o_q;        // Driven data bit
  logic mdio_oe_q;       // Pin drive enable

  wire [12:0] hdr_next = {hdr_q[11:0], mdio_bit};
  wire [1:0] hdr_op = hdr_next[11:10];
  wire [4:0] hdr_phy = hdr_next[9:5];
  wire [4:0] hdr_reg = hdr_next[4:0];
  wire hdr_ok = hdr_next[12] && (hdr_op == OP_READ || hdr_op == OP_WRITE);
  wire hdr_hit = (hdr_phy == PHYAD_PORT1) || (hdr_phy == PHYAD_PORT2);
  wire hdr_port = (hdr_phy == PHYAD_PORT2);
  wire [15:0] rd_word = mii_view(hdr_reg, ca_q[hdr_port], cb_q[hdr_port], st_q[hdr_port],
                                 hdr_port ? 1'b0 : fef_q, an_en_q[hdr_port], rsv9_q[hdr_port]);

  // Engine advances only on accepted MDC rising edges; a bad start or opcode drops the frame
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= PMR_PRE;
      cnt_q <= 6'h00;
      hdr_q <= 13'h0000;
      shf_q <= 16'h0000;
      rd_q <= 1'b0;
      hit_q <= 1'b0;
      port_q <= 1'b0;
      reg_q <= 5'h00;
      mii_wr_q <= 1'b0;
      mdio_o_q <= 1'b0;
      mdio_oe_q <= 1'b0;
    end else begin
      mii_wr_q <= 1'b0;
      if (mdc_rise) begin
        case (state_q)
          PMR_PRE: begin
            // Count ones; a zero after a full preamble is the first start bit
            if (mdio_bit) begin
              cnt_q <= (cnt_q == PREAMBLE_LEN) ? cnt_q : cnt_q + 6'h01;
            end else if (cnt_q == PREAMBLE_LEN) begin
              state_q <= PMR_HDR;
              cnt_q <= 6'h00;
            end else begin
              cnt_q <= 6'h00;
            end
          end
          PMR_HDR: begin
            hdr_q <= hdr_next;
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == HDR_LAST) begin
              cnt_q <= 6'h00;
              state_q <= hdr_ok ? PMR_TA : PMR_PRE;
              rd_q <= (hdr_op == OP_READ);
              hit_q <= hdr_hit;
              port_q <= hdr_port;
              reg_q <= hdr_reg;
              shf_q <= rd_word;
            end
          end
          PMR_TA: begin
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q != 6'h00) begin
              state_q <= PMR_DATA;
              cnt_q <= 6'h00;
            end
            // Second turnaround bit is driven low, then data follows MSB first
            if (rd_q && hit_q) begin
              mdio_oe_q <= 1'b1;
              mdio_o_q <= (cnt_q == 6'h00) ? 1'b0 : shf_q[15];
              if (cnt_q != 6'h00) begin
                shf_q <= {shf_q[14:0], 1'b0};
              end
            end
          end
          PMR_DATA: begin
            cnt_q <= cnt_q + 6'h01;
            if (rd_q) begin
              mdio_o_q <= shf_q[15];
              shf_q <= {shf_q[14:0], 1'b0};
            end else begin
              shf_q <= {shf_q[14:0], mdio_bit};
            end
            if (cnt_q == DATA_LAST) begin
              state_q <= PMR_PRE;
              cnt_q <= 6'h00;
              mdio_oe_q <= 1'b0;
              mdio_o_q <= 1'b0;
              mii_wr_q <= !rd_q && hit_q;
            end
          end
          default: begin
            state_q <= PMR_PRE;
            cnt_q <= 6'h00;
            mdio_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Byte view decode
  // ----------------------------------------------------------------
  wire sw_store_rng = (SW_ADDR >= SW_GLOBAL_LO) && (SW_ADDR <= SW_USER_HI) && (SW_ADDR != SW_RESERVED);
  wire sw_start_set = SW_WE && (SW_ADDR == SW_CHIP_ID1) && SW_WDATA[0];
  wire [1:0] sw_ca_hit = {SW_ADDR == SW_CA_ADDR[1], SW_ADDR == SW_CA_ADDR[0]};
  wire [1:0] sw_cb_hit = {SW_ADDR == SW_CB_ADDR[1], SW_ADDR == SW_CB_ADDR[0]};

  pmr_store_if st_bus();

  assign st_bus.wr = SW_WE && sw_store_rng;
  assign st_bus.addr = SW_ADDR[3:0];
  assign st_bus.wdata = SW_WDATA;

  pmr_store #(.DEPTH(16)) u_store (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .bus(st_bus)
  );

  // Next values: byte view first, management write applied on top in the same cycle
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      ca_d[p] = ca_q[p];
      cb_d[p] = cb_q[p];
      an_en_d[p] = an_en_q[p];
      rsv9_d[p] = rsv9_q[p];
      if (SW_WE && sw_ca_hit[p]) begin
        ca_d[p] = SW_WDATA;
      end
      if (SW_WE && sw_cb_hit[p]) begin
        cb_d[p] = SW_WDATA & CB_MASK[p];
      end
      if (mii_wr_q && (port_q == p[0]) && (reg_q == MII_BASIC_CONTROL)) begin
        cb_d[p][CB_LOOPBACK] = shf_q[BC_LOOPBACK];
        ca_d[p][CA_FORCE100] = shf_q[BC_FORCE100];
        an_en_d[p] = shf_q[BC_AN_EN];
        cb_d[p][CB_POWER_DOWN] = shf_q[BC_POWER_DOWN];
        cb_d[p][CB_RESTART_AN] = shf_q[BC_RESTART_AN];
        ca_d[p][CA_FULL] = shf_q[BC_FULL];
        cb_d[p][CB_FORCE_MDI] = shf_q[BC_FORCE_MDI];
        cb_d[p][CB_NO_MDIX] = shf_q[BC_NO_MDIX];
        cb_d[p][CB_NO_FEF] = shf_q[BC_NO_FEF] & CB_MASK[p][CB_NO_FEF];
        cb_d[p][CB_NO_TX] = shf_q[BC_NO_TX];
        cb_d[p][CB_NO_LED] = shf_q[BC_NO_LED];
      end
      if (mii_wr_q && (port_q == p[0]) && (reg_q == MII_ADVERTISE)) begin
        // Read-only selector and top bits simply have no storage to hit
        ca_d[p][CA_PAUSE] = shf_q[AD_PAUSE];
        rsv9_d[p] = shf_q[AD_RSVD9];
        ca_d[p][CA_ABIL_LO +: 4] = shf_q[AD_ABIL_LO +: 4];
      end
    end
  end

  // Storage registers of both views, plus the flops seen by one view only
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ca_q <= '{CA_RESET, CA_RESET};
      cb_q <= '{CB_RESET, CB_RESET};
      st_q <= '{7'h00, 7'h00};
      an_en_q <= 2'h3;
      rsv9_q <= 2'h0;
      fef_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      ca_q <= ca_d;
      cb_q <= cb_d;
      an_en_q <= an_en_d;
      rsv9_q <= rsv9_d;
      st_q <= '{PHY_STATUS_P1, PHY_STATUS_P2};
      fef_q <= FAR_END_FAULT;
      // Start bit cannot be cleared once set
      start_q <= start_q | sw_start_set;
    end
  end

  // ----------------------------------------------------------------
  // Byte view read path: two cycles, the store answer is already registered
  // ----------------------------------------------------------------
  logic [7:0] loc_q;     // Locally held byte for the read
  logic sel_store_q;     // Read targets the byte store
  logic re_q;            // Read accepted last cycle
  logic [7:0] rdata_q;   // Read data output
  logic rvalid_q;        // Read data valid

  wire [7:0] loc_rd =
      (SW_ADDR == SW_CHIP_ID0) ? CHIP_ID0 :
      (SW_ADDR == SW_CHIP_ID1) ? {CHIP_ID1, start_q} :
      sw_ca_hit[0] ? ca_q[0] :
      sw_ca_hit[1] ? ca_q[1] :
      sw_cb_hit[0] ? cb_q[0] :
      sw_cb_hit[1] ? cb_q[1] :
      (SW_ADDR == SW_ST_ADDR[0]) ? {1'b0, st_q[0]} :
      (SW_ADDR == SW_ST_ADDR[1]) ? {1'b0, st_q[1]} :
      (SW_ADDR == SW_P1_FAULT) ? {7'h00, fef_q} : 8'h00;

  // Read pipeline for the configuration port
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      loc_q <= 8'h00;
      sel_store_q <= 1'b0;
      re_q <= 1'b0;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      loc_q <= loc_rd;
      sel_store_q <= sw_store_rng;
      re_q <= SW_RE;
      rdata_q <= re_q ? (sel_store_q ? st_bus.rdata : loc_q) : rdata_q;
      rvalid_q <= re_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign MDIO_O = mdio_o_q;
  assign MDIO_OE = mdio_oe_q;
  assign SW_RDATA = rdata_q;
  assign SW_RVALID = rvalid_q;
  assign CTRL_A_P1 = ca_q[0];
  assign CTRL_B_P1 = cb_q[0];
  assign CTRL_A_P2 = ca_q[1];
  assign CTRL_B_P2 = cb_q[1];
  assign AN_ENABLE = an_en_q;
  assign START_SWITCH = start_q;

endmodule

// [dv/pmr_monitor.sv]
// Checker for the byte port and the serial data drive of the register bank.
// Assumes it is bound to pmr_top and sees only its ports.
`timescale 1ns/1ps
module pmr_monitor (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic [6:0] SW_ADDR,
  input wire logic SW_WE,
  input wire logic SW_RE,
  input wire logic [7:0] SW_WDATA,
  input wire logic [7:0] SW_RDATA,
  input wire logic SW_RVALID,
  input wire logic [6:0] PHY_STATUS_P1,
  input wire logic FAR_END_FAULT,
  input wire logic [7:0] CTRL_A_P1,
  input wire logic [7:0] CTRL_B_P2,
  input wire logic MDIO_O,
  input wire logic MDIO_OE
);
  // ----------------------------------------------------------------
  // Assertions, all on the core clock
  // ----------------------------------------------------------------
  default clocking mon_clk @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // Byte reads answer two cycles after the strobe, never unasked
  rd_latency_a: assert property (SW_RE |-> ##2 SW_RVALID) else $error("read answer late");
  rvalid_cause_a: assert property (SW_RVALID |-> $past(SW_RE, 2)) else $error("answer without read");
  // Shared bits show a byte write on the next edge
  ca_write_a: assert property (SW_WE && SW_ADDR == 7'h1c |=> CTRL_A_P1 == $past(SW_WDATA))
    else $error("control A write lost");
  // Port 2 has no far-end fault bit, so it never stores one
  cb_write_a: assert property (SW_WE && SW_ADDR == 7'h2d |=> CTRL_B_P2 == ($past(SW_WDATA) & 8'hef))
    else $error("control B write wrong");
  rsvd_read_a: assert property (SW_RE && SW_ADDR == 7'h0c |-> ##2 SW_RDATA == 8'h00)
    else $error("reserved byte not zero");
  // Status pin is registered once before the read pipeline, hence three cycles back
  status_read_a: assert property (SW_RE && SW_ADDR == 7'h1e |-> ##2 SW_RDATA == {1'b0, $past(PHY_STATUS_P1, 3)})
    else $error("status byte wrong");
  fault_read_a: assert property (SW_RE && SW_ADDR == 7'h1f |-> ##2 SW_RDATA[0] == $past(FAR_END_FAULT, 3))
    else $error("fault byte wrong");
  // The turnaround bit we drive first is a zero, then the word follows
  ta_zero_a: assert property ($rose(MDIO_OE) |-> !MDIO_O) else $error("turnaround not zero");
  oe_hold_a: assert property ($rose(MDIO_OE) |-> MDIO_OE [*8]) else $error("drive dropped early");
endmodule
bind pmr_top pmr_monitor i_pmr_monitor (.*);

// [dv/pmr_mgmt_host.sv]
// Station management controller model driving whole serial frames.
// Assumes the bench resolves the shared data line with a pull-up.
`timescale 1ns/1ps
module pmr_mgmt_host (
  output logic mdc,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic mdio
);
  // Clock stands low between frames
  initial begin
    mdc = 1'b0;
    mdio_o = 1'b0;
    mdio_oe = 1'b0;
  end
  // One frame at ten core clocks per bit; read bits are taken at each rise, before the slave reacts
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hffffffff, 2'b01, op, phy, ra, 2'b10, wd};
    for (int i = 63; i >= 0; i--) begin
      mdio_oe = (op == 2'h1) || (i > 17);
      mdio_o = bits[i];
      #125;
      mdc = 1'b1;
      if (i < 16) rd[i] = mdio;
      #125;
      mdc = 1'b0;
    end
    // Release and leave room for the slave to let go and commit
    mdio_oe = 1'b0;
    #250;
  endtask
endmodule

// [dv/pmr_top_bench.sv]
// Self-checking bench for the port management register bank.
// Assumes the host model owns the serial pins and the bench owns the byte port.
`timescale 1ns/1ps
module pmr_top_bench
  import pmr_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic h_mdc, h_o, h_oe, mdio_w, mdio_o, mdio_oe, sw_rvalid, start_switch;
  logic [6:0] sw_addr = 7'h00;
  logic sw_we = 1'b0;
  logic sw_re = 1'b0;
  logic [7:0] sw_wdata = 8'h00;
  logic [7:0] sw_rdata, bd;
  logic [6:0] st [2] = '{7'h00, 7'h00};
  logic fef = 1'b0;
  logic [7:0] ctrl_a [2];
  logic [7:0] ctrl_b [2];
  logic [1:0] an_enable;
  logic [7:0] ca [2] = '{8'h9f, 8'h9f}; // Expected byte controls
  logic [7:0] cb [2] = '{8'h00, 8'h00};
  logic [1:0] an_en = 2'b11; // Expected private flops
  logic [1:0] rsv9 = 2'b00;
  logic [15:0] rd;
  int err_total = 0;
  int tests_run = 0;
  int seed = 42;
  int p;
  // Pull-up on the shared data line
  assign mdio_w = mdio_oe ? mdio_o : (h_oe ? h_o : 1'b1);
  always #12.5 clk_sys = ~clk_sys;
  pmr_top i_pmr_top (.CLK_SYS(clk_sys), .RSTN(rstn), .MDC(h_mdc), .MDIO_I(mdio_w), .MDIO_O(mdio_o),
    .MDIO_OE(mdio_oe), .SW_ADDR(sw_addr), .SW_WE(sw_we), .SW_RE(sw_re), .SW_WDATA(sw_wdata),
    .SW_RDATA(sw_rdata), .SW_RVALID(sw_rvalid), .PHY_STATUS_P1(st[0]), .PHY_STATUS_P2(st[1]),
    .FAR_END_FAULT(fef), .CTRL_A_P1(ctrl_a[0]), .CTRL_B_P1(ctrl_b[0]), .CTRL_A_P2(ctrl_a[1]),
    .CTRL_B_P2(ctrl_b[1]), .AN_ENABLE(an_enable), .START_SWITCH(start_switch));
  pmr_mgmt_host i_pmr_mgmt_host (.mdc(h_mdc), .mdio_o(h_o), .mdio_oe(h_oe), .mdio(mdio_w));
  // ----------------------------------------------------------------
  // Checking and expectation helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Management word as built from the shared byte bits
  function automatic logic [15:0] exp_mii(input int q, input logic [4:0] ra);
    case (ra)
      5'h00: return {1'b0, cb[q][0], ca[q][6], an_en[q], cb[q][3], 1'b0, cb[q][5], ca[q][5], 3'h0,
                     cb[q][1], cb[q][2], cb[q][4], cb[q][6], cb[q][7]};
      5'h01: return {5'h0f, 5'h00, st[q][6], fef & (q == 0), ca[q][7], st[q][5], 2'h0};
      5'h02: return 16'h5a01;
      5'h03: return 16'h0c3e;
      5'h04: return {5'h00, ca[q][4], rsv9[q], ca[q][3:0], 5'h01};
      5'h05: return {5'h00, st[q][4], 1'b0, st[q][3:0], 5'h00};
      default: return 16'h0000;
    endcase
  endfunction
  task automatic mread(input int q, input logic [4:0] ra);
    i_pmr_mgmt_host.frame(OP_READ, 5'(q + 1), ra, 16'h0000, rd);
    chk(rd, exp_mii(q, ra));
  endtask
  // Writes through the serial view, folding the word into the byte expectations
  task automatic mwrite(input int q, input logic [4:0] ra, input logic [15:0] w);
    i_pmr_mgmt_host.frame(OP_WRITE, 5'(q + 1), ra, w, rd);
    if (ra == 5'h00) begin
      cb[q] = {w[0], w[1], w[9], w[2], w[11], w[3], w[4], w[14]} & CB_MASK[q];
      ca[q][6:5] = {w[13], w[8]};
      an_en[q] = w[12];
    end else begin
      ca[q][4:0] = {w[10], w[8:5]};
      rsv9[q] = w[9];
    end
  endtask
  task automatic bwrite(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sw_addr = a;
    sw_wdata = d;
    sw_we = 1'b1;
    @(negedge clk_sys);
    sw_we = 1'b0;
  endtask
  // Answer is looked at in its one valid cycle
  task automatic bread(input logic [6:0] a);
    @(negedge clk_sys);
    sw_addr = a;
    sw_re = 1'b1;
    @(negedge clk_sys);
    sw_re = 1'b0;
    // Valid rises on the next edge and stands one cycle; look at it half a cycle later
    @(negedge clk_sys);
    chk({15'h0000, sw_rvalid}, 16'h0001);
    bd = sw_rdata;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk({ctrl_a[0], ctrl_b[1]}, 16'h9f00);
    chk({15'h0000, start_switch}, 16'h0000);
    // Defaults of registers 0 to 7 of port 1, unsupported numbers 6 and 7 included
    for (int r = 0; r < 8; r++) mread(0, 5'(r));
    // A port address nobody answers leaves the line pulled up
    i_pmr_mgmt_host.frame(OP_READ, 5'h03, 5'h00, 16'h0000, rd);
    chk(rd, 16'hffff);
    // A frame with a bad opcode is dropped: no drive, no write
    i_pmr_mgmt_host.frame(2'h0, 5'h01, MII_ADVERTISE, 16'h0000, rd);
    chk(rd, 16'hffff);
    mread(0, MII_ADVERTISE);
    bwrite(SW_RESERVED, 8'hff);
    bread(SW_RESERVED);
    chk({8'h00, bd}, 16'h0000);
    bwrite(7'h0d, 8'ha5);
    bread(7'h0d);
    chk({8'h00, bd}, 16'h00a5);
    // Start bit sets once and a later zero cannot clear it
    bwrite(SW_CHIP_ID1, 8'h01);
    bwrite(SW_CHIP_ID1, 8'h00);
    bread(SW_CHIP_ID1);
    chk({15'h0000, bd[0]}, 16'h0001);
    chk({15'h0000, start_switch}, 16'h0001);
    // Random traffic through both views
    for (int n = 0; n < 24; n++) begin
      p = $random(seed) & 1;
      st[p] = 7'($random(seed));
      fef = 1'($random(seed));
      bd = 8'($random(seed));
      if (n[0]) begin
        bwrite(SW_CB_ADDR[p], bd);
        cb[p] = bd & CB_MASK[p];
      end else begin
        bwrite(SW_CA_ADDR[p], bd);
        ca[p] = bd;
      end
      mread(p, 5'(n % 6));
      mwrite(p, n[1] ? MII_ADVERTISE : MII_BASIC_CONTROL, 16'($random(seed)));
      chk({ctrl_a[p], ctrl_b[p]}, {ca[p], cb[p]});
      chk({14'h0000, an_enable}, {14'h0000, an_en});
      bread(SW_CB_ADDR[p]);
      chk({8'h00, bd}, {8'h00, cb[p]});
      bread(7'h1e);
      bread(7'h1f);
    end
    mread(0, MII_BASIC_CONTROL);
    mread(1, MII_ADVERTISE);
    results();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #2000000;
    err_total++;
    results();
  end
endmodule
